// ---- bench/lp_seq_chk.sv ----
`timescale 1ns/1ps
module lp_seq_chk
  import lp_seq_pkg::*;
#(
  parameter int PLL_LOCK = 64
) (
  input wire logic i_core_clk, i_rst, i_idle_exec, i_mode_select,
  input wire logic [1:0] i_pll_divide_select,
  input wire logic i_flash_sleeping, i_qual_enable, i_ext_wake,
  input wire logic i_nonmaskable_wake_input, o_system_clock_en,
  input wire logic o_peripheral_clock_en, o_oscillator_en, o_pll_en,
  input wire logic o_watchdog_clock_en, o_cpu_resume, o_wake_irq,
  input wire logic o_standby, o_halt, o_core_input_clock_en
);
  localparam int LOCK_HI = PLL_LOCK + RESUME_RAM + 4;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire run = o_system_clock_en && !o_standby && !o_halt;
  // the enable drops on the edge after the last held cycle
  sequence s_stop;
    o_system_clock_en ##1 !o_system_clock_en;
  endsequence
  a_hold_short: assert property (
    i_idle_exec && run && !i_mode_select && !i_pll_divide_select[1]
    |-> ##16 s_stop) else $error("standby hold");
  a_halt_flush: assert property (
    i_idle_exec && run && i_mode_select |-> ##32 s_stop)
    else $error("halt flush");
  a_core_clk_off: assert property (
    o_halt |-> !o_core_input_clock_en) else $error("core clock running");
  a_osc_restart: assert property (
    o_halt && i_nonmaskable_wake_input |=> o_oscillator_en)
    else $error("oscillator restart");
  a_standby_gate: assert property (
    o_standby |-> !o_peripheral_clock_en && o_pll_en && o_watchdog_clock_en)
    else $error("standby gating");
  a_halt_gate: assert property (
    $rose(o_halt) |-> !(o_peripheral_clock_en || o_oscillator_en || o_pll_en))
    else $error("halt gating");
  a_pll_waits: assert property (
    !o_system_clock_en && !o_standby && i_nonmaskable_wake_input |-> !o_pll_en)
    else $error("pll early");
  a_lock_time: assert property (
    $fell(i_nonmaskable_wake_input) && !o_system_clock_en && !i_flash_sleeping
    |-> ##[PLL_LOCK:LOCK_HI] o_cpu_resume) else $error("lock time");
  a_standby_wake: assert property (
    o_standby && $rose(i_ext_wake) && !i_qual_enable |-> ##[1:14] o_cpu_resume)
    else $error("standby wake");
  a_resume_pulse: assert property (
    $rose(o_cpu_resume) |-> o_wake_irq ##1 !o_cpu_resume)
    else $error("resume pulse");
endmodule : lp_seq_chk

bind standby_halt_power_sequencer lp_seq_chk #(.PLL_LOCK(PLL_LOCK)) chk_inst (
  .i_core_clk, .i_rst, .i_idle_exec, .i_mode_select, .i_pll_divide_select,
  .i_flash_sleeping, .i_qual_enable, .i_ext_wake, .i_nonmaskable_wake_input,
  .o_system_clock_en, .o_peripheral_clock_en, .o_oscillator_en, .o_pll_en,
  .o_watchdog_clock_en, .o_cpu_resume, .o_wake_irq, .o_standby, .o_halt,
  .o_core_input_clock_en);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import lp_seq_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, idle = 1'b0, mode = 1'b0;
  localparam int LOCK = 64;
  logic busy = 1'b0, qen = 1'b0, ext, nmi, rstp, sys, per, osc, pll;
  logic wd, xclk, fail, res, irq, stby, halt, cin;
  logic flash = 1'b0;
  logic [5:0] qc = 6'h03;
  logic [1:0] div = 2'h0;
  logic [2:0] go = 3'h0;
  int n_mismatch = 0, n_checks = 0;
  wire [2:0] mon = {nmi, res, sys};
  initial forever #50 i_core_clk = ~i_core_clk;
  wake_src_model wake_src_model_inst (.i_core_clk, .i_go(go), .o_ext(ext),
    .o_nmi(nmi), .o_rst(rstp));
  standby_halt_power_sequencer #(.PLL_LOCK(LOCK))
    standby_halt_power_sequencer_inst (.i_core_clk, .i_rst,
    .i_idle_exec(idle), .i_mode_select(mode), .i_pll_divide_select(div),
    .i_flash_sleeping(flash), .i_ext_access_busy(busy), .i_qual_enable(qen),
    .i_standby_wake_qualify_count(qc), .i_ext_wake(ext),
    .i_nonmaskable_wake_input(nmi), .i_device_reset_pin(rstp),
    .o_system_clock_en(sys), .o_peripheral_clock_en(per),
    .o_oscillator_en(osc), .o_pll_en(pll), .o_watchdog_clock_en(wd),
    .o_core_input_clock_en(cin), .o_external_clock_output(xclk),
    .o_ext_access_failed(fail), .o_cpu_resume(res), .o_wake_irq(irq),
    .o_standby(stby), .o_halt(halt));
  task automatic check(string nm, logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic wait_is(int b, logic v, output int n);
    n = 0;
    while (mon[b] !== v) begin
      @(negedge i_core_clk);
      n++;
      if (n > 2000) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask : wait_is
  task automatic sleep(logic m, logic [1:0] d);
    mode = m;
    div = d;
    idle = 1'b1;
    @(negedge i_core_clk);
    idle = 1'b0;
  endtask : sleep
  task automatic wake(logic [2:0] src, output int n);
    go <= src;
    @(negedge i_core_clk);
    go <= 3'h0;
    wait_is(1, 1'b1, n);
    check("irq", 8'(irq), 8'h01);
  endtask : wake
  task automatic t_standby(logic [1:0] d, int hold, int lo, int hi);
    int n;
    sleep(MODE_STANDBY, d);
    wait_is(0, 1'b0, n);
    check("hold", 8'(n), 8'(hold));
    check("gates", 8'({stby, per, pll, wd}), 8'h0B);
    wake(3'h1, n);
    check("latency", 8'(n >= lo && n <= hi), 8'h01);
    check("failed", 8'(fail), 8'(busy));
    @(negedge i_core_clk);
    check("pulse", 8'({res, sys}), 8'h01);
  endtask : t_standby
  task automatic t_halt(logic [2:0] src, int res_len);
    int n;
    int hi;
    // wake pulse of eight cycles plus two of slack on top of lock and resume
    hi = LOCK + res_len + 10;
    sleep(MODE_HALT, 2'h0);
    wait_is(0, 1'b0, n);
    check("flush", 8'(n), 8'(HALT_FLUSH));
    repeat (CLKOUT_HIGH_MAX - HALT_FLUSH - 1) @(negedge i_core_clk);
    check("park", 8'({xclk, halt, per, osc, pll, cin}), 8'h30);
    wake(src, n);
    check("lock", 8'(n > LOCK && n <= hi), 8'h01);
  endtask : t_halt
  initial begin
    repeat (10) @(negedge i_core_clk);
    i_rst = 1'b0;
    @(negedge i_core_clk);
    // an access left open across the hold window must be flagged
    busy = 1'b1;
    t_standby(2'h3, 64, 12, 14);
    busy = 1'b0;
    for (int i = 0; i < 3; i++)
      t_standby(2'(i), 16 << (i / 2), 12, 14);
    qen = 1'b1;
    t_standby(2'h2, 32, 17, 19);
    qc = 6'h00;
    t_standby(2'h1, 16, 14, 16);
    qen = 1'b0;
    t_halt(3'h2, RESUME_RAM);
    t_halt(3'h4, RESUME_RAM);
    // sleeping flash stretches the resume phase well past the lock
    flash = 1'b1;
    t_halt(3'h2, RESUME_FLASH);
    flash = 1'b0;
    print_verdict();
  end
endmodule : tb_top

// ---- bench/wake_src_model.sv ----
`timescale 1ns/1ps
module wake_src_model (
  input  wire logic       i_core_clk,
  input  wire logic [2:0] i_go,
  output logic            o_ext,
  output logic            o_nmi,
  output logic            o_rst
);
  logic [2:0] act = 3'h0;
  logic [3:0] cnt = 4'h0;
  // eight cycles covers both pin minimums; released lines go inactive
  always @(negedge i_core_clk) begin
    if (i_go != 3'h0) begin
      act <= i_go;
      cnt <= 4'h8;
    end else if (cnt > 4'h1)
      cnt <= cnt - 4'h1;
    else
      act <= 3'h0;
  end
  assign {o_rst, o_nmi, o_ext} = act;
endmodule : wake_src_model

// ---- rtl/lp_seq_pkg.sv ----
package lp_seq_pkg;
  localparam int HOLD_16          = 16;
  localparam int HOLD_32          = 32;
  localparam int HOLD_64          = 64;
  localparam int HALT_FLUSH       = 32;
  localparam int CLKOUT_HIGH_MAX  = 45;
  localparam int PLL_LOCK_CYCLES  = 131072;
  localparam int RESUME_RAM       = 35;
  localparam int RESUME_FLASH     = 1125;
  localparam int STBY_RESUME      = 12;
  localparam int QUAL_W           = 6;
  localparam int QUAL_EXTRA       = 2;
  localparam int CNT_W            = 18;
  localparam logic [1:0] DIV_32   = 2'h2;
  localparam logic [1:0] DIV_64   = 2'h3;
  localparam logic MODE_STANDBY   = 1'b0;
  localparam logic MODE_HALT      = 1'b1;

  typedef enum logic [3:0] {
    ST_RUN       = 4'h0,
    ST_SB_HOLD   = 4'h1,
    ST_SB_SLEEP  = 4'h3,
    ST_SB_WAKE   = 4'h2,
    ST_HT_HOLD   = 4'h4,
    ST_HT_SLEEP  = 4'hC,
    ST_HT_OSC    = 4'hD,
    ST_HT_LOCK   = 4'h9,
    ST_HT_RESUME = 4'h8
  } lp_state_t;
endpackage : lp_seq_pkg

// ---- rtl/standby_halt_power_sequencer.sv ----
`timescale 1ns/1ps
module standby_halt_power_sequencer
  import lp_seq_pkg::*;
#(
  parameter int PLL_LOCK = lp_seq_pkg::PLL_LOCK_CYCLES
) (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // core side
  input  wire logic              i_idle_exec,
  input  wire logic              i_mode_select,
  input  wire logic [1:0]        i_pll_divide_select,
  input  wire logic              i_flash_sleeping,
  input  wire logic              i_ext_access_busy,
  // low power control fields
  input  wire logic              i_qual_enable,
  input  wire logic [QUAL_W-1:0] i_standby_wake_qualify_count,
  // wake sources
  input  wire logic              i_ext_wake,
  input  wire logic              i_nonmaskable_wake_input,
  input  wire logic              i_device_reset_pin,
  // clock controls
  output logic                   o_system_clock_en,
  output logic                   o_peripheral_clock_en,
  output logic                   o_oscillator_en,
  output logic                   o_pll_en,
  output logic                   o_watchdog_clock_en,
  output logic                   o_core_input_clock_en,
  output logic                   o_external_clock_output,
  // status
  output logic                   o_ext_access_failed,
  output logic                   o_cpu_resume,
  output logic                   o_wake_irq,
  output logic                   o_standby,
  output logic                   o_halt
);
  import lp_seq_pkg::*;

  lp_state_t         state;
  lp_state_t         next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  hold_len;
  logic [CNT_W-1:0]  resume_len;
  logic              cnt_done;
  logic              wake_ok;
  logic              reset_wake;

  // hold length depends on divide select
  always_comb begin
    unique case (i_pll_divide_select)
      DIV_32:  hold_len = CNT_W'(HOLD_32);
      DIV_64:  hold_len = CNT_W'(HOLD_64);
      default: hold_len = CNT_W'(HOLD_16);
    endcase
  end

  // flash wake is slow, ram wake fast
  assign resume_len = i_flash_sleeping ? CNT_W'(RESUME_FLASH)
                                       : CNT_W'(RESUME_RAM);
  assign cnt_done   = (cnt == '0);
  // reset pin wakes from halt as well; its own width is the far side's job
  assign reset_wake = i_device_reset_pin;

  wake_qualifier u_wake_qualifier (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_arm        (state == ST_SB_SLEEP),
    .i_qual_en    (i_qual_enable),
    .i_qual_count (i_standby_wake_qualify_count),
    .i_wake       (i_ext_wake),
    .o_wake_ok    (wake_ok)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN:
        if (i_idle_exec)
          next_state = (i_mode_select == MODE_HALT) ? ST_HT_HOLD
                                                    : ST_SB_HOLD;
      ST_SB_HOLD:
        if (cnt_done) next_state = ST_SB_SLEEP;
      ST_SB_SLEEP:
        if (wake_ok) next_state = ST_SB_WAKE;
      ST_SB_WAKE:
        if (cnt_done) next_state = ST_RUN;
      ST_HT_HOLD:
        if (cnt_done) next_state = ST_HT_SLEEP;
      ST_HT_SLEEP:
        if (i_nonmaskable_wake_input) next_state = ST_HT_OSC;
        else if (reset_wake) next_state = ST_HT_LOCK;
      ST_HT_OSC:
        if (!i_nonmaskable_wake_input) next_state = ST_HT_LOCK;
      ST_HT_LOCK:
        if (cnt_done) next_state = ST_HT_RESUME;
      ST_HT_RESUME:
        if (cnt_done) next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // one down counter reloaded on every state change
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (next_state != state) begin
      unique case (next_state)
        ST_SB_HOLD:   cnt <= hold_len - 1'b1;
        ST_HT_HOLD:   cnt <= CNT_W'(HALT_FLUSH - 1);
        ST_SB_WAKE:   cnt <= CNT_W'(STBY_RESUME - 2);
        ST_HT_LOCK:   cnt <= CNT_W'(PLL_LOCK - 1);
        ST_HT_RESUME: cnt <= resume_len - 2'h2;
        default:      cnt <= '0;
      endcase
    end else if (!cnt_done) begin
      cnt <= cnt - 1'b1;
    end
  end

  // clock enables follow the state; pll and watchdog live in standby
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_system_clock_en     <= 1'b1;
      o_peripheral_clock_en <= 1'b1;
      o_oscillator_en       <= 1'b1;
      o_pll_en              <= 1'b1;
      o_watchdog_clock_en   <= 1'b1;
      o_core_input_clock_en <= 1'b1;
    end else begin
      o_system_clock_en <= !(next_state inside
        {ST_SB_SLEEP, ST_HT_SLEEP, ST_HT_OSC, ST_HT_LOCK});
      o_peripheral_clock_en <= !(next_state inside
        {ST_SB_SLEEP, ST_HT_SLEEP, ST_HT_OSC, ST_HT_LOCK});
      o_oscillator_en  <= (next_state != ST_HT_SLEEP);
      o_pll_en <= !(next_state inside {ST_HT_SLEEP, ST_HT_OSC});
      o_watchdog_clock_en <= !(next_state inside
        {ST_HT_SLEEP, ST_HT_OSC, ST_HT_LOCK});
      o_core_input_clock_en <= !(next_state inside
        {ST_HT_SLEEP, ST_HT_OSC, ST_HT_LOCK});
    end
  end

  // clock output parks high once the clock stops
  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      o_external_clock_output <= 1'b0;
    else if (!(next_state inside {ST_RUN, ST_SB_HOLD, ST_HT_HOLD,
                                  ST_SB_WAKE, ST_HT_RESUME}))
      o_external_clock_output <= 1'b1;
    else
      o_external_clock_output <= !o_external_clock_output;
  end

  // a bus cycle still open when the clock stops cannot finish
  always_ff @(posedge i_core_clk) begin
    if (i_rst)
      o_ext_access_failed <= 1'b0;
    else if (i_idle_exec && state == ST_RUN)
      o_ext_access_failed <= 1'b0;
    else if ((state == ST_SB_HOLD || state == ST_HT_HOLD) && cnt_done
             && i_ext_access_busy)
      o_ext_access_failed <= 1'b1;
  end

  // resume and wake interrupt pulse together on return to run
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cpu_resume <= 1'b0;
      o_wake_irq   <= 1'b0;
      o_standby    <= 1'b0;
      o_halt       <= 1'b0;
    end else begin
      o_cpu_resume <= (state != ST_RUN) && (next_state == ST_RUN);
      o_wake_irq   <= next_state == ST_RUN && state != ST_RUN;
      o_standby    <= (next_state == ST_SB_SLEEP);
      o_halt       <= next_state inside
        {ST_HT_SLEEP, ST_HT_OSC, ST_HT_LOCK};
    end
  end
endmodule : standby_halt_power_sequencer

// ---- rtl/wake_qualifier.sv ----
`timescale 1ns/1ps
module wake_qualifier
  import lp_seq_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // qualification control
  input  wire logic              i_arm,
  input  wire logic              i_qual_en,
  input  wire logic [QUAL_W-1:0] i_qual_count,
  // wake input and result
  input  wire logic              i_wake,
  output logic                   o_wake_ok
);
  logic [QUAL_W:0] width;

  // pulse must last count plus two cycles when qualified
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_arm || !i_wake) begin
      width     <= '0;
      o_wake_ok <= 1'b0;
    end else begin
      if (width != '1)
        width <= width + 1'b1;
      if (!i_qual_en)
        o_wake_ok <= 1'b1;
      else if ({1'b0, width} + 8'h01 >=
               {2'h0, i_qual_count} + 8'(QUAL_EXTRA))
        o_wake_ok <= 1'b1;
    end
  end
endmodule : wake_qualifier
